// File: core/rcc_pkg.sv
package rcc_pkg;

  // Fabric clock and line rates in kHz, and the fabric clock period in ns.
  localparam longint CLK_KHZ       = 40000;
  localparam longint T1_KHZ        = 1544;
  localparam longint E1_KHZ        = 2048;
  localparam int     CLK_PERIOD_NS = 25;

  // Reset and access timing.
  localparam int     RESET_MIN_NS     = 100;
  localparam int     RESET_MIN_CYCLES = (RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam longint READY_TIME_US    = 2000;
  localparam int     READY_CYCLES     = int'(READY_TIME_US * CLK_KHZ / 64'd1000);

  // Host port and internal datapath widths.
  localparam int ADDR_W = 9;
  localparam int DATA_W = 8;
  localparam int FREQ_W = 14;
  localparam int BASE_W = 12;
  localparam int NCO_W  = 24;

  localparam logic [BASE_W-1:0] T1_BASE_KHZ = BASE_W'(T1_KHZ);
  localparam logic [BASE_W-1:0] E1_BASE_KHZ = BASE_W'(E1_KHZ);

  // Phase increments giving two ticks per line-rate period.
  localparam logic [NCO_W-1:0] NCO_INC_T1 = NCO_W'((64'd2 * T1_KHZ * (64'd1 << NCO_W)) / CLK_KHZ);
  localparam logic [NCO_W-1:0] NCO_INC_E1 = NCO_W'((64'd2 * E1_KHZ * (64'd1 << NCO_W)) / CLK_KHZ);

  // Register offsets.
  localparam logic [ADDR_W-1:0] OFS_GENERAL_PIN_CONTROL = 9'h006;
  localparam logic [ADDR_W-1:0] OFS_REF_OUT_LINK_SELECT = 9'h007;
  localparam logic [ADDR_W-1:0] OFS_REF_LOSS_FALLBACK   = 9'h03e;

  // Field positions.
  localparam int BIT_GP_PIN_DIRECTION   = 0;
  localparam int BIT_GP_PIN_LEVEL       = 2;
  localparam int BIT_FIRST_REF_LINK_SEL = 0;
  localparam int BIT_SECOND_REF_LINK_SEL = 3;
  localparam int BIT_REF_FALLBACK_HIGH  = 0;

  // Values after reset.
  localparam logic RST_GP_PIN_DIRECTION = 1'b0;
  localparam logic RST_GP_PIN_LEVEL     = 1'b0;
  localparam logic RST_REF_LINK_SEL     = 1'b0;
  localparam logic RST_FALLBACK_HIGH    = 1'b0;
  localparam logic RST_TEST_MODE        = 1'b1;

  typedef enum logic [1:0] {
    RCC_ST_WAIT = 2'b01,
    RCC_ST_OPEN = 2'b10
  } rcc_access_st_t;

endpackage

// File: core/rcc_rate_gen.sv
`timescale 1ns/1ps
module rcc_rate_gen #(
  parameter int W = 24
) (
  input  wire logic         clock_i,
  input  wire logic         rst_n_i,
  input  wire logic [W-1:0] inc_i,
  output logic              tick_o
);
  import rcc_pkg::*;

  logic [W-1:0] acc_r;
  logic [W:0]   sum_w;
  logic         tick_r;

  assign sum_w  = {1'b0, acc_r} + {1'b0, inc_i};
  assign tick_o = tick_r;

  // The carry out of the phase accumulator is the enable pulse; the fraction
  // left in the accumulator keeps the long-term rate exact.
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      acc_r  <= '0;
      tick_r <= 1'b0;
    end else begin
      acc_r  <= sum_w[W-1:0];
      tick_r <= sum_w[W];
    end
  end

endmodule

// File: core/rcc_chip_ctrl.sv
`timescale 1ns/1ps
// Overview of operation
// - Top strap low means oscillator is multiple of 1.544 MHz, high 2.048 MHz.
// - Lower two straps give multiplier: 00 one, 01 two, 10 three, 11 four.
// - Generated clock output carries the line-rate clock, 1.544 or 2.048 MHz.
// - Without loss, first reference carries recovered clock of link chosen by link select bit 0.
// - Without loss, second reference carries recovered clock of link chosen by link select bit 3.
// - On loss, each reference carries master clock or steady high per fallback register bit 0.
// - Master clock is derived from the fabric clock, 2.048 MHz E1 or 1.544 MHz T1 per the top strap.
// - Reset low longer than 100 ns resets the whole device.
// - Registers open to the host only 2 ms after reset ends.
// - Bit 0 of the general pin control register sets general pin direction.
// - Bit 2 of general pin control reads pin level as input, sets it as output.
// - High transmit tristate input puts all line transmit pairs in high impedance.
// - Interrupt output stays low until all active unmasked indications clear.
// - Chip select high after power-up clears the internal test modes.
// - Oscillator frequency is interpreted from the three clock-select straps.
module rcc_chip_ctrl #(
  parameter int NUM_LINKS      = 2,
  parameter int NUM_INT        = 8,
  parameter int READY_CYCLES_P = rcc_pkg::READY_CYCLES
) (
  input  wire logic                        clock_i,
  input  wire logic                        nrst_i,
  input  wire logic [2:0]                  clk_sel_i,
  output logic [rcc_pkg::FREQ_W-1:0]       osc_freq_khz_o,
  output logic                             line_is_e1_o,
  output logic                             generated_clock_out_o,
  input  wire logic [NUM_LINKS-1:0]        rec_clk_i,
  input  wire logic [NUM_LINKS-1:0]        loss_of_signal_i,
  output logic                             ref_out_first_o,
  output logic                             ref_out_second_o,
  input  wire logic                        cs_n_i,
  input  wire logic                        rd_n_i,
  input  wire logic                        wr_n_i,
  input  wire logic [rcc_pkg::ADDR_W-1:0]  addr_i,
  input  wire logic [rcc_pkg::DATA_W-1:0]  data_i,
  output logic [rcc_pkg::DATA_W-1:0]       data_o,
  output logic                             data_oe_o,
  input  wire logic                        gp_pin_i,
  output logic                             gp_pin_o,
  output logic                             gp_pin_oe_o,
  input  wire logic                        line_tx_tristate_i,
  output logic [NUM_LINKS-1:0]             line_tx_pair_oe_o,
  input  wire logic [NUM_INT-1:0]          int_src_i,
  output logic                             int_n_o,
  output logic                             int_n_oe_o,
  output logic                             test_mode_o,
  output logic                             regs_ready_o
);
  import rcc_pkg::*;

  localparam int SYNC_W = ADDR_W + DATA_W + 3 + 2 * NUM_LINKS + 5;
  localparam int CNT_W  = $clog2(READY_CYCLES_P + 1);

  logic [1:0]              rst_q_r;
  logic                    rst_n;
  logic [SYNC_W-1:0]       meta_r;
  logic [SYNC_W-1:0]       sync_r;
  logic [ADDR_W-1:0]       addr_s;
  logic [DATA_W-1:0]       wdata_s;
  logic [2:0]              clk_sel_s;
  logic [NUM_LINKS-1:0]    rec_s;
  logic [NUM_LINKS-1:0]    los_s;
  logic                    cs_s;
  logic                    rd_s;
  logic                    wr_s;
  logic                    gp_in_s;
  logic                    tx_hiz_s;
  logic                    cs_idle_w;
  logic                    wr_prev_r;
  logic                    wr_take_w;
  rcc_access_st_t          st_r;
  rcc_access_st_t          st_nxt;
  logic [CNT_W-1:0]        cnt_r;
  logic                    ready_w;
  logic                    gp_dir_r;
  logic                    gp_level_r;
  logic                    ref1_sel_r;
  logic                    ref2_sel_r;
  logic                    fb_high_r;
  logic                    test_mode_r;
  logic [DATA_W-1:0]       data_r;
  logic                    data_oe_r;
  logic [DATA_W-1:0]       rd_mux_w;
  logic                    gp_level_rd_w;
  logic [2:0]              osc_mult_w;
  logic [BASE_W-1:0]       osc_base_w;
  logic [FREQ_W-1:0]       osc_khz_w;
  logic [FREQ_W-1:0]       osc_khz_r;
  logic [NCO_W-1:0]        nco_inc_w;
  logic                    tick_w;
  logic                    mclk_r;
  logic                    fallback_w;
  logic                    los1_w;
  logic                    los2_w;
  logic                    ref1_r;
  logic                    ref2_r;
  logic                    gp_oe_r;
  logic                    gp_out_r;
  logic [NUM_LINKS-1:0]    tx_oe_r;
  logic                    int_oe_r;

  // Any low level resets at once; release is synchronised to the clock.
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rst_q_r <= 2'h0;
    end else begin
      rst_q_r <= {rst_q_r[0], 1'b1};
    end
  end
  assign rst_n = rst_q_r[1];

  // Pins other than nrst_i and int_src_i come through this synchroniser; only sync_r is read further on.
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= '1;
      sync_r <= '1;
    end else begin
      meta_r <= {addr_i, data_i, clk_sel_i, rec_clk_i, loss_of_signal_i,
                 cs_n_i, rd_n_i, wr_n_i, gp_pin_i, line_tx_tristate_i};
      sync_r <= meta_r;
    end
  end
  assign {addr_s, wdata_s, clk_sel_s, rec_s, los_s, cs_s, rd_s, wr_s, gp_in_s, tx_hiz_s} = sync_r;

  // Oscillator frequency from the straps.
  assign osc_mult_w = {1'b0, clk_sel_s[1:0]} + 3'h1;
  assign osc_base_w = clk_sel_s[2] ? E1_BASE_KHZ : T1_BASE_KHZ;
  assign osc_khz_w  = FREQ_W'(osc_mult_w) * FREQ_W'(osc_base_w);

  // Master clock rate follows the base family of the oscillator.
  assign nco_inc_w = clk_sel_s[2] ? NCO_INC_E1 : NCO_INC_T1;

  rcc_rate_gen #(
    .W (NCO_W)
  ) u_rate_gen (
    .clock_i (clock_i),
    .rst_n_i (rst_n),
    .inc_i   (nco_inc_w),
    .tick_o  (tick_w)
  );

  // Register access opens only after the settle interval.
  always_comb begin
    st_nxt = st_r;
    case (st_r)
      RCC_ST_WAIT: begin
        if (cnt_r == CNT_W'(READY_CYCLES_P - 1)) begin
          st_nxt = RCC_ST_OPEN;
        end
      end
      RCC_ST_OPEN: st_nxt = RCC_ST_OPEN;
      default:     st_nxt = RCC_ST_WAIT;
    endcase
  end
  assign ready_w = (st_r == RCC_ST_OPEN);

  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      st_r  <= RCC_ST_WAIT;
      cnt_r <= '0;
    end else begin
      st_r  <= st_nxt;
      cnt_r <= (st_r == RCC_ST_WAIT) ? cnt_r + CNT_W'(1) : cnt_r;
    end
  end

  // A write lands on the rising write strobe while chip select is low.
  assign wr_take_w = !wr_prev_r && wr_s && !cs_s && ready_w;

  // The synchroniser shows its reset level for two cycles after reset; that level
  // is not a chip select seen high and must not clear the test mode.
  assign cs_idle_w = cs_s && (ready_w || cnt_r >= CNT_W'(2));

  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      wr_prev_r   <= 1'b1;
      gp_dir_r    <= RST_GP_PIN_DIRECTION;
      gp_level_r  <= RST_GP_PIN_LEVEL;
      ref1_sel_r  <= RST_REF_LINK_SEL;
      ref2_sel_r  <= RST_REF_LINK_SEL;
      fb_high_r   <= RST_FALLBACK_HIGH;
      test_mode_r <= RST_TEST_MODE;
    end else begin
      wr_prev_r <= wr_s;
      if (cs_idle_w) begin
        test_mode_r <= 1'b0;
      end
      if (wr_take_w && addr_s == OFS_GENERAL_PIN_CONTROL) begin
        gp_dir_r   <= wdata_s[BIT_GP_PIN_DIRECTION];
        gp_level_r <= wdata_s[BIT_GP_PIN_LEVEL];
      end
      if (wr_take_w && addr_s == OFS_REF_OUT_LINK_SELECT) begin
        ref1_sel_r <= wdata_s[BIT_FIRST_REF_LINK_SEL];
        ref2_sel_r <= wdata_s[BIT_SECOND_REF_LINK_SEL];
      end
      if (wr_take_w && addr_s == OFS_REF_LOSS_FALLBACK) begin
        fb_high_r <= wdata_s[BIT_REF_FALLBACK_HIGH];
      end
    end
  end

  // As an input the level bit shows the pin, as an output the stored value.
  assign gp_level_rd_w = gp_dir_r ? gp_level_r : gp_in_s;

  always_comb begin
    rd_mux_w = '0;
    case (addr_s)
      OFS_GENERAL_PIN_CONTROL: begin
        rd_mux_w[BIT_GP_PIN_DIRECTION] = gp_dir_r;
        rd_mux_w[BIT_GP_PIN_LEVEL]     = gp_level_rd_w;
      end
      OFS_REF_OUT_LINK_SELECT: begin
        rd_mux_w[BIT_FIRST_REF_LINK_SEL]  = ref1_sel_r;
        rd_mux_w[BIT_SECOND_REF_LINK_SEL] = ref2_sel_r;
      end
      OFS_REF_LOSS_FALLBACK: rd_mux_w[BIT_REF_FALLBACK_HIGH] = fb_high_r;
      default: rd_mux_w = '0;
    endcase
  end

  // Loss is judged on the link each output currently uses.
  assign los1_w     = los_s[ref1_sel_r];
  assign los2_w     = los_s[ref2_sel_r];
  assign fallback_w = fb_high_r ? 1'b1 : mclk_r;

  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      data_r    <= '0;
      data_oe_r <= 1'b0;
      osc_khz_r <= '0;
      mclk_r    <= 1'b0;
      ref1_r    <= 1'b1;
      ref2_r    <= 1'b1;
      gp_oe_r   <= 1'b0;
      gp_out_r  <= 1'b0;
      tx_oe_r   <= '0;
      int_oe_r  <= 1'b0;
    end else begin
      data_r    <= rd_mux_w;
      data_oe_r <= !cs_s && !rd_s && ready_w;
      osc_khz_r <= osc_khz_w;
      mclk_r    <= tick_w ? !mclk_r : mclk_r;
      ref1_r    <= los1_w ? fallback_w : rec_s[ref1_sel_r];
      ref2_r    <= los2_w ? fallback_w : rec_s[ref2_sel_r];
      gp_oe_r   <= gp_dir_r;
      gp_out_r  <= gp_level_r;
      tx_oe_r   <= {NUM_LINKS{!tx_hiz_s}};
      int_oe_r  <= |int_src_i;
    end
  end

  assign osc_freq_khz_o        = osc_khz_r;
  assign line_is_e1_o          = clk_sel_s[2];
  assign generated_clock_out_o = mclk_r;
  assign ref_out_first_o       = ref1_r;
  assign ref_out_second_o      = ref2_r;
  assign data_o                = data_r;
  assign data_oe_o             = data_oe_r;
  assign gp_pin_o              = gp_out_r;
  assign gp_pin_oe_o           = gp_oe_r;
  assign line_tx_pair_oe_o     = tx_oe_r;
  // Open drain: the pad is only ever pulled low.
  assign int_n_o               = 1'b0;
  assign int_n_oe_o            = int_oe_r;
  assign test_mode_o           = test_mode_r;
  assign regs_ready_o          = ready_w;

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n);

  sequence s_mclk_hold;
    !$changed(mclk_r) [*8];
  endsequence
  sequence s_mclk_edge;
    ##[1:6] $changed(mclk_r);
  endsequence

  property p_mclk_period;
    $changed(mclk_r) |=> s_mclk_hold ##0 s_mclk_edge;
  endproperty
  a_mclk_period: assert property (p_mclk_period) else $error("master clock period off");

  property p_freq_e1x4;
    (clk_sel_s == 3'h7) |=> (osc_freq_khz_o == 14'h2000);
  endproperty
  a_freq_e1x4: assert property (p_freq_e1x4) else $error("strap decode wrong for E1 x4");

  property p_freq_t1x1;
    (clk_sel_s == 3'h0) |=> (osc_freq_khz_o == 14'h0608);
  endproperty
  a_freq_t1x1: assert property (p_freq_t1x1) else $error("strap decode wrong for T1 x1");

  property p_ref1_rec;
    !los1_w |=> (ref_out_first_o == $past(rec_s[ref1_sel_r]));
  endproperty
  a_ref1_rec: assert property (p_ref1_rec) else $error("first ref not recovered");

  property p_ref2_rec;
    !los2_w |=> (ref_out_second_o == $past(rec_s[ref2_sel_r]));
  endproperty
  a_ref2_rec: assert property (p_ref2_rec) else $error("second ref not recovered");

  property p_ref_fallback;
    (los1_w && fb_high_r) ##1 (los1_w && fb_high_r) |-> ref_out_first_o;
  endproperty
  a_ref_fallback: assert property (p_ref_fallback) else $error("fallback high not held");

  property p_early_closed;
    !regs_ready_o |=> !data_oe_o && $stable(ref1_sel_r) && $stable(gp_dir_r);
  endproperty
  a_early_closed: assert property (p_early_closed) else $error("access before ready");

  property p_gp_drive;
    gp_dir_r |=> gp_pin_oe_o && (gp_pin_o == $past(gp_level_r));
  endproperty
  a_gp_drive: assert property (p_gp_drive) else $error("general pin not driven");

  property p_tx_hiz;
    tx_hiz_s |=> (line_tx_pair_oe_o == '0);
  endproperty
  a_tx_hiz: assert property (p_tx_hiz) else $error("line pair driven in tristate");

  property p_int_hold;
    (int_src_i != '0) |=> int_n_oe_o;
  endproperty
  a_int_hold: assert property (p_int_hold) else $error("interrupt released early");

  property p_test_clear;
    cs_idle_w |=> !test_mode_o;
  endproperty
  a_test_clear: assert property (p_test_clear) else $error("test mode not cleared");

endmodule

// File: verif/rcc_link_model.sv
`timescale 1ns/1ps
module rcc_link_model (
  input  wire logic       clock_i,
  input  wire logic       run_i,
  input  wire logic [1:0] loss_i,
  output logic      [1:0] rec_clk_o,
  output logic      [1:0] loss_of_signal_o
);
  logic [4:0] cnt_r;

  initial cnt_r = 5'h00;
  always @(posedge clock_i) begin
    cnt_r <= cnt_r + 5'h01;
  end
  // Stopped links park at opposite levels so that a wrong selection shows.
  assign rec_clk_o        = run_i ? {cnt_r[4], cnt_r[3]} : 2'b01;
  assign loss_of_signal_o = loss_i;
endmodule

// File: verif/test_ref_clock_and_chip_control.sv
`timescale 1ns/1ps
module test_ref_clock_and_chip_control;
  import rcc_pkg::*;
  logic              clock_i, nrst_i, cs_n_i, rd_n_i, wr_n_i, gp_pin_i, txz, run;
  logic [2:0]        clk_sel_i;
  logic [ADDR_W-1:0] addr_i;
  logic [DATA_W-1:0] data_i, data_o;
  logic [FREQ_W-1:0] osc_freq;
  logic [1:0]        rec_clk, loss_of_signal, loss_req, tx_oe;
  logic [7:0]        int_src;
  logic              is_e1, gen_clk, ref_a, ref_b, data_oe, gp_o, gp_oe;
  logic              int_n, int_oe, test_mode, ready, seen0, seen1;
  int                num_errors, checks, cycles, rises, w;

  rcc_chip_ctrl #(.READY_CYCLES_P(20)) uut (
    .clock_i(clock_i), .nrst_i(nrst_i), .clk_sel_i(clk_sel_i),
    .osc_freq_khz_o(osc_freq), .line_is_e1_o(is_e1), .generated_clock_out_o(gen_clk),
    .rec_clk_i(rec_clk), .loss_of_signal_i(loss_of_signal), .ref_out_first_o(ref_a),
    .ref_out_second_o(ref_b), .cs_n_i(cs_n_i), .rd_n_i(rd_n_i), .wr_n_i(wr_n_i),
    .addr_i(addr_i), .data_i(data_i), .data_o(data_o), .data_oe_o(data_oe),
    .gp_pin_i(gp_pin_i), .gp_pin_o(gp_o), .gp_pin_oe_o(gp_oe),
    .line_tx_tristate_i(txz), .line_tx_pair_oe_o(tx_oe), .int_src_i(int_src),
    .int_n_o(int_n), .int_n_oe_o(int_oe), .test_mode_o(test_mode), .regs_ready_o(ready));
  rcc_link_model link (.clock_i(clock_i), .run_i(run), .loss_i(loss_req),
    .rec_clk_o(rec_clk), .loss_of_signal_o(loss_of_signal));

  initial begin
    clock_i = 1'b0;
    forever #12.5 clock_i = ~clock_i;
  end

  task automatic results;
    if (num_errors == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clock_i);
  endtask

  // The commit happens on the strobe's rising edge, so hold it long enough.
  task automatic wr(input logic [8:0] a, input logic [7:0] d, input logic sel);
    cs_n_i <= ~sel;
    addr_i <= a;
    data_i <= d;
    wr_n_i <= 1'b0;
    cyc(4);
    wr_n_i <= 1'b1;
    cyc(4);
    cs_n_i <= 1'b1;
    cyc(4);
  endtask

  task automatic rd(input logic [8:0] a, input logic [7:0] exp);
    cs_n_i <= 1'b0;
    rd_n_i <= 1'b0;
    addr_i <= a;
    cyc(4);
    #1;
    check(data_o, exp);
    check(data_oe, 1'b1);
    cyc(1);
    rd_n_i <= 1'b1;
    cs_n_i <= 1'b1;
    cyc(5);
    #1;
    check(data_oe, 1'b0);
    cyc(1);
  endtask

  task automatic watch(input int n);
    logic p;
    p = gen_clk;
    rises = 0;
    seen0 = 1'b0;
    seen1 = 1'b0;
    repeat (n) begin
      @(negedge clock_i);
      rises += int'(gen_clk && !p);
      p = gen_clk;
      seen0 |= !ref_a;
      seen1 |= ref_a;
    end
    @(posedge clock_i);
  endtask

  task automatic wait_ready;
    w = 0;
    while (ready !== 1'b1 && w < 200) begin
      cyc(1);
      w++;
    end
  endtask

  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      results();
    end
  end

  initial begin
    longint k;
    nrst_i = 1'b0;
    cs_n_i = 1'b0;
    rd_n_i = 1'b1;
    wr_n_i = 1'b1;
    addr_i = '0;
    data_i = '0;
    gp_pin_i = 1'b0;
    txz = 1'b0;
    int_src = 8'h00;
    clk_sel_i = 3'h0;
    run = 1'b0;
    loss_req = 2'h0;
    cyc(10);
    check(test_mode, 1'b1);
    nrst_i <= 1'b1;
    cyc(4);
    check(test_mode, 1'b1);
    wr(OFS_REF_OUT_LINK_SELECT, 8'h09, 1'b1);
    check(ready, 1'b0);
    wait_ready();
    check(w >= 6 && w <= 14, 1'b1);
    check(test_mode, 1'b0);
    rd(OFS_REF_OUT_LINK_SELECT, 8'h00);
    wr(OFS_REF_OUT_LINK_SELECT, 8'h09, 1'b0);
    rd(OFS_REF_OUT_LINK_SELECT, 8'h00);
    wr(9'h100, 8'hff, 1'b1);
    rd(9'h100, 8'h00);
    rd(OFS_GENERAL_PIN_CONTROL, 8'h00);
    rd(OFS_REF_LOSS_FALLBACK, 8'h00);
    wr(OFS_REF_OUT_LINK_SELECT, 8'hff, 1'b1);
    rd(OFS_REF_OUT_LINK_SELECT, 8'h09);
    for (int i = 0; i < 4; i++) begin
      wr(OFS_REF_OUT_LINK_SELECT, {4'h0, i[1], 2'h0, i[0]}, 1'b1);
      check(ref_a, !i[0]);
      check(ref_b, !i[1]);
    end
    loss_req <= 2'b10;
    wr(OFS_REF_LOSS_FALLBACK, 8'h01, 1'b1);
    check({ref_a, ref_b}, 2'b11);
    wr(OFS_REF_LOSS_FALLBACK, 8'h00, 1'b1);
    watch(60);
    check({seen0, seen1}, 2'b11);
    loss_req <= 2'b01;
    cyc(6);
    check({ref_a, ref_b}, 2'b00);
    loss_req <= 2'b00;
    run <= 1'b1;
    for (int c = 0; c < 8; c++) begin
      clk_sel_i <= c[2:0];
      cyc(6);
      k = (c[2] ? E1_KHZ : T1_KHZ);
      check(osc_freq, 16'(k * (c[1:0] + 1)));
      check(is_e1, c[2]);
      if (c[1:0] == 2'b00) begin
        watch(1000);
        k = k * 1000 / CLK_KHZ;
        check(rises >= k - 1 && rises <= k + 1, 1'b1);
      end
    end
    run <= 1'b0;
    gp_pin_i <= 1'b1;
    cyc(4);
    rd(OFS_GENERAL_PIN_CONTROL, 8'h04);
    check(gp_oe, 1'b0);
    wr(OFS_GENERAL_PIN_CONTROL, 8'hff, 1'b1);
    check({gp_oe, gp_o}, 2'b11);
    rd(OFS_GENERAL_PIN_CONTROL, 8'h05);
    wr(OFS_GENERAL_PIN_CONTROL, 8'h01, 1'b1);
    check({gp_oe, gp_o}, 2'b10);
    rd(OFS_GENERAL_PIN_CONTROL, 8'h01);
    txz <= 1'b1;
    cyc(5);
    check(tx_oe, 2'b00);
    txz <= 1'b0;
    cyc(5);
    check(tx_oe, 2'b11);
    int_src <= 8'h21;
    cyc(3);
    check({int_n, int_oe}, 2'b01);
    int_src <= 8'h20;
    cyc(3);
    check(int_oe, 1'b1);
    int_src <= 8'h00;
    cyc(3);
    check(int_oe, 1'b0);
    nrst_i <= 1'b0;
    cyc(5);
    check({ready, test_mode}, 2'b01);
    nrst_i <= 1'b1;
    wait_ready();
    rd(OFS_REF_OUT_LINK_SELECT, 8'h00);
    results();
  end
endmodule
